//--- pkg/trse_pkg.sv
// Purpose: Constants for the transmission range status encoder
// Assumes: 32-bit AXI4-Lite register access
// Notes: Field codes match the network signal encodings
`default_nettype none
package trse_pkg;
   // ----------------------------------------
   // Field codes
   // ----------------------------------------
   localparam logic [3:0] RNG_BETWEEN = 4'h0;
   localparam logic [3:0] RNG_PARK = 4'h1;
   localparam logic [3:0] RNG_REVERSE = 4'h2;
   localparam logic [3:0] RNG_NEUTRAL = 4'h3;
   localparam logic [3:0] RNG_FWD_A = 4'h4;
   localparam logic [3:0] RNG_FWD_F = 4'h9;
   localparam logic [3:0] RNG_UNKNOWN = 4'hF;
   localparam logic [2:0] FWD_MAX = 3'h6;
   localparam logic VALID_OK = 1'h0;
   localparam logic VALID_BAD = 1'h1;
   localparam logic [2:0] OVR_NONE = 3'h0;
   localparam logic [2:0] OVR_PERF = 3'h1;
   localparam logic [2:0] OVR_LIFT = 3'h2;
   localparam logic [2:0] OVR_GRADE = 3'h3;
   localparam logic [2:0] PAT_DEFAULT = 3'h0;
   localparam logic [1:0] TAP_NONE = 2'h0;
   localparam logic [1:0] TAP_DSC = 2'h1;
   localparam logic [1:0] TAP_ERS = 2'h2;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] CFG_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam int CFG_FWD_LSB = 0;
   localparam int CFG_MANUAL_BIT = 3;
   localparam int CFG_OVR_BIT = 4;
   localparam int CFG_SENSE_BIT = 5;
   localparam logic [2:0] CFG_FWD_RST = 3'h6;
   localparam logic CFG_MANUAL_RST = 1'h0;
   localparam logic CFG_OVR_RST = 1'h1;
   localparam logic CFG_SENSE_RST = 1'h1;
   localparam int ST_RANGE_LSB = 0;
   localparam int ST_INV_BIT = 4;
   localparam int ST_OVR_LSB = 5;
   localparam int ST_PAT_LSB = 8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Refresh period of every field, 10 ns clock: one cycle
   localparam int CLK_NS = 10;
   localparam int REFRESH_NS = 10;
   localparam int REFRESH_CYC = (REFRESH_NS + CLK_NS - 1) / CLK_NS;
endpackage : trse_pkg
`default_nettype wire

//--- core/trse_encoder.sv
// Purpose: Encode lever range, validity, override mode and pattern status
// Assumes: Sensing pins are asynchronous; bus is AXI4-Lite, 32-bit
// Notes: All fields refresh together every enabled clock
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`default_nettype none

// Operation
// - Lever range is 4 bits: 0 between, 1 P, 2 R, 3 N, 4-9 A-F, 15 unknown.
// - Forward range A is the one nearest neutral, codes rise away from it.
// - Lever between defined positions gives the between-ranges code.
// - Only forward codes from A up to the configured count are emitted.
// - With electronic range selection, report the switch-selected forward range.
// - Manual gearbox: reverse switch gives reverse, else unknown without sensing.
// - Validity bit goes invalid when sensor is unreliable and fault logged.
// - Override mode is 3 bits: none, performance, lift-foot, grade braking.
// - Active driver-visible mode is reported; protective overrides are not.
// - No driver-visible mode active gives the no-override code.
// - Driver shift control active forces the no-override code.
// - Manual or no override support holds the no-override code.
// - Pattern status reports the most recently activated pattern switch.
// - All switches off gives default; codes 5 and 6 are never emitted.
module trse_encoder
   import trse_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   // Sensing pins
   input wire logic [3:0] lever_pos_i,
   input wire logic sensor_unreliable_i,
   input wire logic fault_logged_i,
   input wire logic reverse_sw_i,
   input wire logic [2:0] ers_range_i,
   input wire logic [1:0] tap_mode_i,
   input wire logic perf_mode_i,
   input wire logic lift_mode_i,
   input wire logic grade_mode_i,
   input wire logic [3:0] pattern_sw_i,
   // Encoded fields
   output logic [3:0] lever_range_o,
   output logic range_invalid_o,
   output logic [2:0] override_mode_o,
   output logic [2:0] pattern_status_o,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   localparam int PW = 19;

   typedef struct packed {
      logic [PW-1:0] sync1;
      logic [PW-1:0] sync2;
      logic [3:0] pat_prev;
      logic [3:0] range;
      logic inv;
      logic [2:0] ovr;
      logic [2:0] pat;
      logic [2:0] cfg_fwd;
      logic cfg_manual;
      logic cfg_ovr;
      logic cfg_sense;
      logic [7:0] awaddr;
      logic aw_got;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic w_got;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } trse_state_s;

   localparam trse_state_s RST = '{
      sync1: '0,
      sync2: '0,
      pat_prev: 4'h0,
      range: RNG_UNKNOWN,
      inv: VALID_OK,
      ovr: OVR_NONE,
      pat: PAT_DEFAULT,
      cfg_fwd: CFG_FWD_RST,
      cfg_manual: CFG_MANUAL_RST,
      cfg_ovr: CFG_OVR_RST,
      cfg_sense: CFG_SENSE_RST,
      awaddr: 8'h00,
      aw_got: 1'b0,
      wdata: 32'h0000_0000,
      wstrb: 4'h0,
      w_got: 1'b0,
      awready: 1'b1,
      wready: 1'b1,
      bvalid: 1'b0,
      bresp: RESP_OKAY,
      arready: 1'b1,
      rvalid: 1'b0,
      rdata: 32'h0000_0000,
      rresp: RESP_OKAY
   };

   trse_state_s s;
   trse_state_s next_s;

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   // Forward index 0 = A, clipped to configured count
   function automatic logic [3:0] fwd_code(
      input logic [2:0] idx,
      input logic [2:0] cnt
   );
      logic [2:0] lim;
      lim = (cnt > FWD_MAX) ? FWD_MAX : cnt;
      if (idx < lim) begin
         fwd_code = RNG_FWD_A + {1'b0, idx};
      end else begin
         fwd_code = RNG_UNKNOWN;
      end
   endfunction : fwd_code

   function automatic logic [31:0] reg_read(
      input trse_state_s st,
      input logic [7:0] addr
   );
      reg_read = 32'h0000_0000;
      if (addr == CFG_OFS) begin
         reg_read[CFG_FWD_LSB +: 3] = st.cfg_fwd;
         reg_read[CFG_MANUAL_BIT] = st.cfg_manual;
         reg_read[CFG_OVR_BIT] = st.cfg_ovr;
         reg_read[CFG_SENSE_BIT] = st.cfg_sense;
      end else if (addr == STAT_OFS) begin
         reg_read[ST_RANGE_LSB +: 4] = st.range;
         reg_read[ST_INV_BIT] = st.inv;
         reg_read[ST_OVR_LSB +: 3] = st.ovr;
         reg_read[ST_PAT_LSB +: 3] = st.pat;
      end
   endfunction : reg_read

   function automatic logic addr_ok(input logic [7:0] addr);
      addr_ok = (addr == CFG_OFS) || (addr == STAT_OFS);
   endfunction : addr_ok

   // ----------------------------------------
   // Synchronised pins
   // ----------------------------------------
   logic [PW-1:0] raw;
   logic [3:0] p_lever;
   logic p_unrel;
   logic p_logged;
   logic p_rev;
   logic [2:0] p_ers;
   logic [1:0] p_tap;
   logic p_perf;
   logic p_lift;
   logic p_grade;
   logic [3:0] p_pat;

   assign raw = {lever_pos_i, sensor_unreliable_i, fault_logged_i, reverse_sw_i,
                 ers_range_i, tap_mode_i, perf_mode_i, lift_mode_i,
                 grade_mode_i, pattern_sw_i};
   assign {p_lever, p_unrel, p_logged, p_rev, p_ers, p_tap, p_perf, p_lift,
           p_grade, p_pat} = s.sync2;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   logic [3:0] auto_rng;
   logic [3:0] pat_rise;
   logic do_wr;

   always_comb begin
      next_s = s;

      // ----------------------------------------
      // Two-stage pin synchroniser
      // ----------------------------------------
      next_s.sync1 = raw;
      next_s.sync2 = s.sync1;

      // ----------------------------------------
      // Lever range from position sensing
      // ----------------------------------------
      if (p_lever == RNG_BETWEEN) begin
         auto_rng = RNG_BETWEEN;
      end else if (p_lever < RNG_FWD_A) begin
         auto_rng = p_lever;
      end else if (p_lever <= RNG_FWD_F) begin
         if (p_tap == TAP_ERS) begin
            auto_rng = fwd_code(p_ers, s.cfg_fwd);
         end else begin
            auto_rng = fwd_code(3'(p_lever - RNG_FWD_A), s.cfg_fwd);
         end
      end else begin
         auto_rng = RNG_UNKNOWN;
      end

      if (s.cfg_manual && p_rev) begin
         next_s.range = RNG_REVERSE;
      end else if (!s.cfg_sense) begin
         next_s.range = RNG_UNKNOWN;
      end else begin
         next_s.range = auto_rng;
      end

      // ----------------------------------------
      // Validity flag
      // ----------------------------------------
      next_s.inv = (p_unrel && p_logged) ? VALID_BAD : VALID_OK;

      // ----------------------------------------
      // Override mode, driver-visible modes only
      // ----------------------------------------
      if (s.cfg_manual || !s.cfg_ovr) begin
         next_s.ovr = OVR_NONE;
      end else if (p_tap == TAP_DSC) begin
         next_s.ovr = OVR_NONE;
      end else if (p_perf) begin
         next_s.ovr = OVR_PERF;
      end else if (p_lift) begin
         next_s.ovr = OVR_LIFT;
      end else if (p_grade) begin
         next_s.ovr = OVR_GRADE;
      end else begin
         next_s.ovr = OVR_NONE;
      end

      // ----------------------------------------
      // Pattern status: latest rising switch, lowest index wins a tie
      // ----------------------------------------
      pat_rise = p_pat & ~s.pat_prev;
      next_s.pat_prev = p_pat;
      if (p_pat == 4'h0) begin
         next_s.pat = PAT_DEFAULT;
      end else if (pat_rise[0]) begin
         next_s.pat = 3'h1;
      end else if (pat_rise[1]) begin
         next_s.pat = 3'h2;
      end else if (pat_rise[2]) begin
         next_s.pat = 3'h3;
      end else if (pat_rise[3]) begin
         next_s.pat = 3'h4;
      end

      // ----------------------------------------
      // Write channel
      // ----------------------------------------
      if (s_axi_awvalid && s.awready) begin
         next_s.awaddr = s_axi_awaddr;
         next_s.aw_got = 1'b1;
      end
      if (s_axi_wvalid && s.wready) begin
         next_s.wdata = s_axi_wdata;
         next_s.wstrb = s_axi_wstrb;
         next_s.w_got = 1'b1;
      end
      if (s.bvalid && s_axi_bready) begin
         next_s.bvalid = 1'b0;
      end
      do_wr = s.aw_got && s.w_got && !s.bvalid;
      if (do_wr) begin
         next_s.aw_got = 1'b0;
         next_s.w_got = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = addr_ok(s.awaddr) ? RESP_OKAY : RESP_SLVERR;
         if (s.awaddr == CFG_OFS && s.wstrb[0]) begin
            next_s.cfg_fwd = s.wdata[CFG_FWD_LSB +: 3];
            next_s.cfg_manual = s.wdata[CFG_MANUAL_BIT];
            next_s.cfg_ovr = s.wdata[CFG_OVR_BIT];
            next_s.cfg_sense = s.wdata[CFG_SENSE_BIT];
         end
      end
      next_s.awready = !next_s.aw_got && !next_s.bvalid;
      next_s.wready = !next_s.w_got && !next_s.bvalid;

      // ----------------------------------------
      // Read channel
      // ----------------------------------------
      if (s.rvalid && s_axi_rready) begin
         next_s.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s.arready) begin
         next_s.rvalid = 1'b1;
         next_s.rdata = reg_read(s, s_axi_araddr);
         next_s.rresp = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      next_s.arready = !next_s.rvalid;
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         s <= RST;
      end else if (ce_i) begin
         s <= next_s;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign lever_range_o = s.range;
   assign range_invalid_o = s.inv;
   assign override_mode_o = s.ovr;
   assign pattern_status_o = s.pat;
   assign s_axi_awready = s.awready;
   assign s_axi_wready = s.wready;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_arready = s.arready;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;

endmodule : trse_encoder
`default_nettype wire

//--- tb/trse_display_model.sv
// Purpose: Display-side receiver of the encoded range fields
// Assumes: Forward count is given by the bench
// Notes: Blank high means the range display is dark
`default_nettype none
module trse_display_model
   import trse_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic [3:0] lever_range_i,
   input wire logic range_invalid_i,
   input wire logic [2:0] fwd_cnt_i,
   output logic blank_o
);
   logic shown;
   // No lamp output: lamp comes from engaged state
   assign shown = (lever_range_i >= RNG_PARK && lever_range_i <= RNG_NEUTRAL) ||
      (lever_range_i >= RNG_FWD_A && lever_range_i < RNG_FWD_A + {1'b0, fwd_cnt_i});
   always_ff @(posedge sys_clk_i) begin
      blank_o <= !nrst_i || !shown || range_invalid_i;
   end
endmodule : trse_display_model
`default_nettype wire

//--- tb/trse_encoder_sva.sv
// Purpose: Field code and timing checks
// Assumes: Three enabled edges from pin to field
// Notes: Configuration is not visible here
`default_nettype none
module trse_encoder_sva
   import trse_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic [3:0] lever_pos_i,
   input wire logic sensor_unreliable_i,
   input wire logic fault_logged_i,
   input wire logic [1:0] tap_mode_i,
   input wire logic perf_mode_i,
   input wire logic lift_mode_i,
   input wire logic grade_mode_i,
   input wire logic [3:0] pattern_sw_i,
   input wire logic [3:0] lever_range_o,
   input wire logic range_invalid_o,
   input wire logic [2:0] override_mode_o,
   input wire logic [2:0] pattern_status_o
);
   logic [2:0] ce_h;
   logic ok, bad, idle, off;
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!nrst_i);
   assign ok = &ce_h;
   assign bad = sensor_unreliable_i && fault_logged_i;
   assign idle = !(perf_mode_i || lift_mode_i || grade_mode_i);
   assign off = pattern_sw_i == 4'h0;
   always_ff @(posedge sys_clk_i) begin
      ce_h <= nrst_i ? {ce_h[1:0], ce_i} : 3'h0;
   end
   range_set_a: assert property (lever_range_o inside {[4'h0:4'h9], 4'hF})
      else $error("range code unused");
   between_src_a: assert property (ok && lever_range_o == RNG_BETWEEN |->
      $past(lever_pos_i, 3) == 4'h0) else $error("between code without lever gap");
   invalid_flag_a: assert property (ok |-> range_invalid_o == $past(bad, 3))
      else $error("validity flag wrong");
   override_set_a: assert property (override_mode_o <= OVR_GRADE)
      else $error("override code reserved");
   override_idle_a: assert property (ok && $past(idle, 3) |-> override_mode_o == OVR_NONE)
      else $error("override without mode");
   tap_clear_a: assert property (ok && $past(tap_mode_i, 3) == TAP_DSC |->
      override_mode_o == OVR_NONE) else $error("override during driver shift");
   pattern_set_a: assert property (pattern_status_o <= 3'h4)
      else $error("pattern code reserved");
   pattern_idle_a: assert property (ok && $past(off, 3) |-> pattern_status_o == PAT_DEFAULT)
      else $error("pattern not default");
   cover property (ok && lever_range_o == RNG_REVERSE);
   cover property (range_invalid_o);
   cover property (pattern_status_o == 3'h4);
endmodule : trse_encoder_sva
bind trse_encoder trse_encoder_sva u_trse_encoder_sva (.sys_clk_i, .nrst_i, .ce_i,
   .lever_pos_i, .sensor_unreliable_i, .fault_logged_i, .tap_mode_i, .perf_mode_i,
   .lift_mode_i, .grade_mode_i, .pattern_sw_i, .lever_range_o, .range_invalid_o,
   .override_mode_o, .pattern_status_o);
`default_nettype wire

//--- tb/trse_encoder_test.sv
// Purpose: Self-checking bench for the range status encoder
// Assumes: Forward count mirrored into the display model
// Notes: Table rows first, then bus and configuration cases
`default_nettype none
module trse_encoder_test
   import trse_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [3:0] pos;
      logic [1:0] diag;
      logic [1:0] tap;
      logic [2:0] electronic_range_selection;
      logic [2:0] mode;
      logic [3:0] rng;
      logic inv;
      logic [2:0] ovr;
      logic blank;
   } trse_row_s;
   logic sys_clk_i = 1'b0, nrst_i = 1'b0, ce_i = 1'b1, reverse_sw_i = 1'b0, blank;
   logic sensor_unreliable_i = 1'b0, fault_logged_i = 1'b0, range_invalid_o;
   logic perf_mode_i = 1'b0, lift_mode_i = 1'b0, grade_mode_i = 1'b0;
   logic [3:0] lever_pos_i = 4'h0, pattern_sw_i = 4'h0, s_axi_wstrb = 4'hF, lever_range_o;
   logic [2:0] ers_range_i = 3'h0, fwd_cnt = 3'h6, override_mode_o, pattern_status_o;
   logic [1:0] tap_mode_i = 2'h0, s_axi_bresp, s_axi_rresp;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   int mismatches = 0, check_count = 0;
   trse_row_s rows [13] = '{
      '{4'h0, 2'h0, 2'h0, 3'h0, 3'h0, 4'h0, 1'h0, 3'h0, 1'h1},
      '{4'h1, 2'h0, 2'h0, 3'h0, 3'h4, 4'h1, 1'h0, 3'h1, 1'h0},
      '{4'h2, 2'h0, 2'h0, 3'h0, 3'h2, 4'h2, 1'h0, 3'h2, 1'h0},
      '{4'h3, 2'h0, 2'h0, 3'h0, 3'h1, 4'h3, 1'h0, 3'h3, 1'h0},
      '{4'h4, 2'h0, 2'h0, 3'h0, 3'h6, 4'h4, 1'h0, 3'h1, 1'h0},
      '{4'h9, 2'h0, 2'h0, 3'h0, 3'h3, 4'h9, 1'h0, 3'h2, 1'h0},
      '{4'hC, 2'h0, 2'h0, 3'h0, 3'h0, 4'hF, 1'h0, 3'h0, 1'h1},
      '{4'h5, 2'h3, 2'h0, 3'h0, 3'h0, 4'h5, 1'h1, 3'h0, 1'h1},
      '{4'h5, 2'h2, 2'h0, 3'h0, 3'h0, 4'h5, 1'h0, 3'h0, 1'h0},
      '{4'h6, 2'h1, 2'h1, 3'h0, 3'h7, 4'h6, 1'h0, 3'h0, 1'h0},
      '{4'h4, 2'h0, 2'h2, 3'h3, 3'h0, 4'h7, 1'h0, 3'h0, 1'h0},
      '{4'h2, 2'h0, 2'h2, 3'h3, 3'h0, 4'h2, 1'h0, 3'h0, 1'h0},
      '{4'h7, 2'h0, 2'h2, 3'h6, 3'h0, 4'hF, 1'h0, 3'h0, 1'h1}};
   logic [3:0] pat_in [5] = '{4'h2, 4'hA, 4'h2, 4'h0, 4'h5};
   logic [2:0] pat_exp [5] = '{3'h2, 3'h4, 3'h4, 3'h0, 3'h1};
   trse_encoder u_trse_encoder (.sys_clk_i, .nrst_i, .ce_i, .lever_pos_i, .sensor_unreliable_i,
      .fault_logged_i, .reverse_sw_i, .ers_range_i, .tap_mode_i, .perf_mode_i, .lift_mode_i,
      .grade_mode_i, .pattern_sw_i, .lever_range_o, .range_invalid_o, .override_mode_o,
      .pattern_status_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   trse_display_model u_trse_display_model (.sys_clk_i, .nrst_i, .lever_range_i(lever_range_o),
      .range_invalid_i(range_invalid_o), .fwd_cnt_i(fwd_cnt), .blank_o(blank));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic settle;
      repeat (5) @(posedge sys_clk_i);
   endtask : settle
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge sys_clk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge sys_clk_i);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk({30'h0, s_axi_bresp}, {30'h0, er});
   endtask : axw
   task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge sys_clk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge sys_clk_i);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, ed);
      chk({30'h0, s_axi_rresp}, {30'h0, er});
   endtask : axr
   task automatic conclude;
      if (mismatches == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : conclude
   always #5 sys_clk_i = ~sys_clk_i;
   initial begin
      repeat (5000) @(posedge sys_clk_i);
      mismatches++;
      conclude();
   end
   initial begin
      repeat (16) @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      foreach (rows[i]) begin
         lever_pos_i <= rows[i].pos;
         {sensor_unreliable_i, fault_logged_i} <= rows[i].diag;
         tap_mode_i <= rows[i].tap;
         ers_range_i <= rows[i].electronic_range_selection;
         {perf_mode_i, lift_mode_i, grade_mode_i} <= rows[i].mode;
         settle();
         chk(lever_range_o, rows[i].rng);
         chk(range_invalid_o, rows[i].inv);
         chk(override_mode_o, rows[i].ovr);
         chk(blank, rows[i].blank);
      end
      axr(CFG_OFS, 32'h36, RESP_OKAY);
      axr(8'h08, 32'h0, RESP_SLVERR);
      axw(8'h0C, 32'h0, RESP_SLVERR);
      axw(STAT_OFS, 32'h7FF, RESP_OKAY);
      axr(STAT_OFS, 32'h0000000F, RESP_OKAY);
      axw(CFG_OFS, 32'h33, RESP_OKAY);
      fwd_cnt <= 3'h3;
      tap_mode_i <= TAP_NONE;
      settle();
      chk(lever_range_o, RNG_UNKNOWN);
      lever_pos_i <= 4'h6;
      settle();
      chk(lever_range_o, 4'h6);
      axw(CFG_OFS, 32'h1E, RESP_OKAY);
      fwd_cnt <= 3'h6;
      reverse_sw_i <= 1'b1;
      perf_mode_i <= 1'b1;
      settle();
      chk(lever_range_o, RNG_REVERSE);
      chk(override_mode_o, OVR_NONE);
      reverse_sw_i <= 1'b0;
      settle();
      chk(lever_range_o, RNG_UNKNOWN);
      axw(CFG_OFS, 32'h26, RESP_OKAY);
      axr(CFG_OFS, 32'h26, RESP_OKAY);
      settle();
      chk(override_mode_o, OVR_NONE);
      axw(CFG_OFS, 32'h36, RESP_OKAY);
      settle();
      chk(override_mode_o, OVR_PERF);
      for (int k = 0; k < 5; k++) begin
         pattern_sw_i <= pat_in[k];
         settle();
         chk(pattern_status_o, pat_exp[k]);
      end
      ce_i <= 1'b0;
      lever_pos_i <= RNG_NEUTRAL;
      settle();
      chk(lever_range_o, 4'h6);
      ce_i <= 1'b1;
      settle();
      chk(lever_range_o, RNG_NEUTRAL);
      nrst_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      chk(lever_range_o, RNG_UNKNOWN);
      chk(pattern_status_o, PAT_DEFAULT);
      nrst_i <= 1'b1;
      axr(CFG_OFS, 32'h36, RESP_OKAY);
      conclude();
   end
endmodule : trse_encoder_test
`default_nettype wire
